/* File: verilog/urps_pkg.sv */
// Summary of operation
// - error status is read-only, reset to zero
// - parity mismatch sets status bit 2
// - missing stop bit sets status bit 1
// - frame done before buffer read sets bit 0
// - receiver checks only one stop bit
// - overrun repeats every frame until buffer read
// - codes 0-7 divide clock, 8 selects pin
// - internal rate is clock over 2^(n+2) times 8
// - pin rate is pin clock over 16
// - frame: start, 7/8 data, parity, 1/2 stop
// - seven-bit mode drops/zeroes data bit 7
// - even parity transmit makes total ones even
// - even parity receive flags odd count
// - odd parity transmit makes total ones odd
// - odd parity receive flags even count
// - parity codes: none, zero, odd, even
// - buffer read clears flags, next frame rewrites them
package urps_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE = 16'hFF70;  // uart_mode_control
  localparam logic [15:0] ADDR_STAT = 16'hFF71;  // uart_receive_error_status
  localparam logic [15:0] ADDR_BAUD = 16'hFF73;  // baud_source_select
  localparam logic [15:0] ADDR_DATA = 16'hFF75;  // receive_buffer / transmit data

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_TXE     = 7;  // transmit enable
  localparam int MODE_RXE     = 6;  // receive enable
  localparam int MODE_PS_HI   = 5;  // parity_select_high
  localparam int MODE_PS_LO   = 4;  // parity_select_low
  localparam int MODE_CL      = 3;  // character_length_select
  localparam int MODE_SL      = 2;  // stop_length_select
  localparam int STAT_PE      = 2;  // parity_error_flag
  localparam int STAT_FE      = 1;  // framing_error_flag
  localparam int STAT_OVE     = 0;  // overrun_error_flag
  localparam int BAUD_CODE_LO = 4;  // low bit of baud source code

  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] STAT_RST  = 8'h00;
  localparam logic [3:0] BAUD_RST  = 4'h0;
  localparam logic [7:0] MODE_WMSK = 8'hFC;  // bits 1:0 read zero

  // ---------------------------------------------------------------
  // codes and timing counts
  // ---------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  localparam logic [3:0] BAUD_EXT_CODE = 4'h8;  // external pin source
  localparam logic [2:0] TICK_LAST     = 3'h7;  // 8 ticks per bit
  localparam logic [2:0] TICK_HALF     = 3'h3;  // half bit after start edge
  localparam logic [3:0] LAST_BIT_8    = 4'h7;
  localparam logic [3:0] LAST_BIT_7    = 4'h6;
  localparam logic [8:0] DIV_MASK_MAX  = 9'h1FF;  // fx / 2^9 for code 7

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } urps_state_t;

  typedef struct packed {
    logic [15:0] addr;   // byte address
    logic        wr;     // write strobe, one cycle
    logic        rd;     // read strobe, one cycle
    logic [7:0]  wdata;  // write data
  } urps_cpu_req_t;

  // parity of a character: 1 when its count of ones is odd
  function automatic logic urps_ones_odd(input logic [7:0] c);
    return ^c;
  endfunction

endpackage

/* File: verilog/urps_sync.sv */
`timescale 1ns/1ns
module urps_sync #(
  parameter logic RST_LVL = 1'b1
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  import urps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ff;   // three-stage chain
    logic       lvl;  // accepted level
  } urps_sync_st_t;

  urps_sync_st_t st_r;
  urps_sync_st_t st_nxt;

  // chain shift; change accepted once stages two and three agree
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.ff[0] = din;
    st_nxt.ff[1] = st_r.ff[0];
    st_nxt.ff[2] = st_r.ff[1];
    if (st_r.ff[1] == st_r.ff[2])
    begin
      st_nxt.lvl = st_r.ff[2];
    end
  end

  // registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= {{3{RST_LVL}}, RST_LVL};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.lvl;
endmodule // urps_sync

/* File: verilog/urps_baud.sv */
`timescale 1ns/1ns
module urps_baud (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [3:0] code,     // baud source code
  input  wire logic       ext_lvl,  // synchronised external baud clock
  output logic            tick      // one pulse per eighth of a bit
);
  import urps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [8:0] cnt;       // free running prescaler
    logic       ext_prev;  // previous pin level
    logic       ext_half;  // divide pin edges by two
    logic       tick;      // output pulse
  } urps_baud_st_t;

  urps_baud_st_t st_r;
  urps_baud_st_t st_nxt;
  logic [8:0]    mask;     // ones for 2^(n+2) period

  // tick every 2^(n+2) clocks gives fx / 2^(n+2) / 8 per bit
  always_comb
  begin
    mask            = DIV_MASK_MAX >> (3'h7 - code[2:0]);
    st_nxt          = st_r;
    st_nxt.cnt      = st_r.cnt + 9'h001;
    st_nxt.ext_prev = ext_lvl;
    st_nxt.tick     = 1'b0;
    if (code < BAUD_EXT_CODE)
    begin
      // internal source, codes 0 to 7
      st_nxt.tick = ((st_r.cnt & mask) == mask);
    end
    else if (code == BAUD_EXT_CODE)
    begin
      // pin source: two edges per tick, 16 edges per bit
      if (ext_lvl && !st_r.ext_prev)
      begin
        st_nxt.ext_half = !st_r.ext_half;
        st_nxt.tick     = st_r.ext_half;
      end
    end
    // prohibited codes produce no tick
  end

  // registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;
endmodule // urps_baud

/* File: verilog/urps_top.sv */
`timescale 1ns/1ns
module urps_top (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire urps_pkg::urps_cpu_req_t cpu_req,        // cpu access
  output logic [7:0]                   cpu_rdata,      // read data, next cycle
  input  wire logic                    rxd,            // serial receive pin
  output logic                         txd,            // serial transmit pin
  input  wire logic                    external_baud_clock_pin,
  output logic                         rx_done,        // frame stored, pulse
  output logic                         tx_done,        // frame sent, pulse
  output logic                         tx_busy         // transmitter active
);
  import urps_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  mode;      // uart_mode_control
    logic [3:0]  baud;      // baud source code
    logic [2:0]  errs;      // parity, framing, overrun flags
    logic [7:0]  rxbuf;     // receive_buffer
    logic        rx_full;   // buffer holds unread byte
    logic [7:0]  rdata;     // read data register
    urps_state_t rx_st;     // receiver state
    logic [2:0]  rx_tc;     // receiver tick count
    logic [3:0]  rx_bn;     // receiver bit index
    logic [7:0]  rx_sh;     // receive shift register
    logic        rx_pb;     // received parity bit
    urps_state_t tx_st;     // transmitter state
    logic [2:0]  tx_tc;     // transmitter tick count
    logic [3:0]  tx_bn;     // transmitter bit index
    logic [7:0]  tx_sh;     // transmit shift register
    logic        tx_pb;     // parity bit to send
    logic        txd;       // line level
    logic        rx_done;   // completion pulse
    logic        tx_done;   // completion pulse
    logic        tx_busy;   // transmitter active, registered copy
  } urps_top_st_t;

  urps_top_st_t st_r;
  urps_top_st_t st_nxt;

  logic       rxd_s;      // synchronised receive line
  logic       ext_s;      // synchronised pin clock
  logic       tick;       // bit eighth tick
  logic       txe;        // transmit enable
  logic       rxe;        // receive enable
  logic [1:0] psel;       // parity select
  logic       cl8;        // eight-bit characters
  logic       sl2;        // two stop bits
  logic [3:0] last_bit;   // index of last character bit
  logic       rd_data;    // cpu reads receive buffer
  logic       wr_data;    // cpu writes transmit data
  logic [7:0] rx_char;    // assembled character
  logic [7:0] tx_char;    // masked transmit character
  logic       pe;         // parity error of this frame

  // ---------------------------------------------------------------
  // pin synchronisers and baud generator
  // ---------------------------------------------------------------
  urps_sync #(.RST_LVL(1'b1)) u_rxd_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (rxd),
    .dout    (rxd_s)
  );

  urps_sync #(.RST_LVL(1'b0)) u_ext_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .din     (external_baud_clock_pin),
    .dout    (ext_s)
  );

  urps_baud u_baud (
    .mclk    (mclk),
    .reset_n (reset_n),
    .code    (st_r.baud),
    .ext_lvl (ext_s),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // field split of the mode register
  always_comb
  begin
    txe      = st_r.mode[MODE_TXE];
    rxe      = st_r.mode[MODE_RXE];
    psel     = {st_r.mode[MODE_PS_HI], st_r.mode[MODE_PS_LO]};
    cl8      = st_r.mode[MODE_CL];
    sl2      = st_r.mode[MODE_SL];
    last_bit = cl8 ? LAST_BIT_8 : LAST_BIT_7;
    rd_data  = cpu_req.rd && (cpu_req.addr == ADDR_DATA);
    wr_data  = cpu_req.wr && (cpu_req.addr == ADDR_DATA);
  end

  // ---------------------------------------------------------------
  // frame arithmetic
  // ---------------------------------------------------------------
  // character and parity check of the finished frame
  always_comb
  begin
    rx_char = cl8 ? st_r.rx_sh : {1'b0, st_r.rx_sh[7:1]};
    tx_char = cl8 ? cpu_req.wdata : {1'b0, cpu_req.wdata[6:0]};
    case (psel)
      PAR_ODD:  pe = !(urps_ones_odd(rx_char) ^ st_r.rx_pb);
      PAR_EVEN: pe = urps_ones_odd(rx_char) ^ st_r.rx_pb;
      default:  pe = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.rx_done = 1'b0;
    st_nxt.tx_done = 1'b0;

    // register writes; status register has no write path
    if (cpu_req.wr && (cpu_req.addr == ADDR_MODE))
    begin
      st_nxt.mode = cpu_req.wdata & MODE_WMSK;
    end
    if (cpu_req.wr && (cpu_req.addr == ADDR_BAUD))
    begin
      st_nxt.baud = cpu_req.wdata[BAUD_CODE_LO +: 4];
    end

    // register reads, answered one cycle later
    if (cpu_req.rd)
    begin
      case (cpu_req.addr)
        ADDR_MODE: st_nxt.rdata = st_r.mode;
        ADDR_STAT: st_nxt.rdata = {5'h00, st_r.errs};
        ADDR_BAUD: st_nxt.rdata = {st_r.baud, 4'h0};
        ADDR_DATA: st_nxt.rdata = st_r.rxbuf;
        default:   st_nxt.rdata = 8'h00;
      endcase
    end

    // reading the buffer clears the flags
    if (rd_data)
    begin
      st_nxt.rx_full = 1'b0;
      st_nxt.errs    = 3'h0;
    end

    // receiver
    if (!rxe)
    begin
      // stop at once, buffer and flags untouched
      st_nxt.rx_st = ST_IDLE;
    end
    else if (tick)
    begin
      st_nxt.rx_tc = st_r.rx_tc + 3'h1;
      case (st_r.rx_st)
        ST_IDLE:
        begin
          // falling line starts the half bit wait
          if (!rxd_s)
          begin
            st_nxt.rx_st = ST_START;
            st_nxt.rx_tc = 3'h0;
          end
        end
        ST_START:
        begin
          // confirm start bit at mid bit
          if (st_r.rx_tc == TICK_HALF)
          begin
            st_nxt.rx_st = rxd_s ? ST_IDLE : ST_DATA;
            st_nxt.rx_tc = 3'h0;
            st_nxt.rx_bn = 4'h0;
          end
        end
        ST_DATA:
        begin
          // sample character bits, lsb first
          if (st_r.rx_tc == TICK_LAST)
          begin
            st_nxt.rx_sh = {rxd_s, st_r.rx_sh[7:1]};
            st_nxt.rx_bn = st_r.rx_bn + 4'h1;
            if (st_r.rx_bn == last_bit)
            begin
              st_nxt.rx_st = (psel == PAR_NONE) ? ST_STOP : ST_PAR;
            end
          end
        end
        ST_PAR:
        begin
          // sample parity bit
          if (st_r.rx_tc == TICK_LAST)
          begin
            st_nxt.rx_pb = rxd_s;
            st_nxt.rx_st = ST_STOP;
          end
        end
        ST_STOP:
        begin
          // one stop bit only, then store byte and flags
          if (st_r.rx_tc == TICK_LAST)
          begin
            st_nxt.rx_st            = ST_IDLE;
            st_nxt.rxbuf            = rx_char;
            st_nxt.rx_full          = 1'b1;
            st_nxt.rx_done          = 1'b1;
            st_nxt.errs[STAT_PE]    = pe;
            st_nxt.errs[STAT_FE]    = !rxd_s;
            st_nxt.errs[STAT_OVE]   = st_r.rx_full && !rd_data;
          end
        end
        default:
        begin
          st_nxt.rx_st = ST_IDLE;
        end
      endcase
    end

    // transmitter
    if (!txe)
    begin
      st_nxt.tx_st = ST_IDLE;
      st_nxt.txd   = 1'b1;
    end
    else if ((st_r.tx_st == ST_IDLE) && wr_data)
    begin
      // load character, parity chosen from masked data
      st_nxt.tx_st = ST_START;
      st_nxt.tx_sh = tx_char;
      st_nxt.tx_tc = 3'h0;
      st_nxt.txd   = 1'b0;
      case (psel)
        PAR_ODD:  st_nxt.tx_pb = !urps_ones_odd(tx_char);
        PAR_EVEN: st_nxt.tx_pb = urps_ones_odd(tx_char);
        default:  st_nxt.tx_pb = 1'b0;
      endcase
    end
    else if (tick && (st_r.tx_st != ST_IDLE))
    begin
      st_nxt.tx_tc = st_r.tx_tc + 3'h1;
      if (st_r.tx_tc == TICK_LAST)
      begin
        case (st_r.tx_st)
          ST_START:
          begin
            // first character bit
            st_nxt.tx_st = ST_DATA;
            st_nxt.tx_bn = 4'h0;
            st_nxt.txd   = st_r.tx_sh[0];
            st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
          end
          ST_DATA:
          begin
            // next bit, then parity or stop
            st_nxt.tx_bn = st_r.tx_bn + 4'h1;
            st_nxt.txd   = st_r.tx_sh[0];
            st_nxt.tx_sh = {1'b0, st_r.tx_sh[7:1]};
            if (st_r.tx_bn == last_bit)
            begin
              st_nxt.tx_bn = 4'h0;
              if (psel == PAR_NONE)
              begin
                st_nxt.tx_st = ST_STOP;
                st_nxt.txd   = 1'b1;
              end
              else
              begin
                st_nxt.tx_st = ST_PAR;
                st_nxt.txd   = st_r.tx_pb;
              end
            end
          end
          ST_PAR:
          begin
            // parity sent, begin stop
            st_nxt.tx_st = ST_STOP;
            st_nxt.txd   = 1'b1;
          end
          ST_STOP:
          begin
            // one or two stop bits
            if (sl2 && (st_r.tx_bn == 4'h0))
            begin
              st_nxt.tx_bn = 4'h1;
            end
            else
            begin
              st_nxt.tx_st   = ST_IDLE;
              st_nxt.tx_done = 1'b1;
            end
          end
          default:
          begin
            st_nxt.tx_st = ST_IDLE;
            st_nxt.txd   = 1'b1;
          end
        endcase
      end
    end

    // busy flop mirrors the next transmitter state so the pin needs no decode
    st_nxt.tx_busy = (st_nxt.tx_st != ST_IDLE);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r       <= '0;
      st_r.mode  <= MODE_RST;
      st_r.baud  <= BAUD_RST;
      st_r.errs  <= STAT_RST[2:0];
      st_r.rx_st <= ST_IDLE;
      st_r.tx_st <= ST_IDLE;
      st_r.txd   <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign cpu_rdata = st_r.rdata;
  assign txd       = st_r.txd;
  assign rx_done   = st_r.rx_done;
  assign tx_done   = st_r.tx_done;
  assign tx_busy   = st_r.tx_busy;
endmodule // urps_top

/* File: sim/urps_properties.sv */
`timescale 1ns/1ns
module urps_properties (
  input wire logic                    mclk,
  input wire logic                    reset_n,
  input wire urps_pkg::urps_cpu_req_t cpu_req,
  input wire logic [7:0]              cpu_rdata,
  input wire logic                    rxd,
  input wire logic                    txd,
  input wire logic                    external_baud_clock_pin,
  input wire logic                    rx_done,
  input wire logic                    tx_done,
  input wire logic                    tx_busy
);
  import urps_pkg::*;

  // ------
  // bus decode and shadow state
  // ------
  logic rd_stat;   // status read
  logic rd_baud;   // baud select read
  logic rd_data;   // buffer read
  logic wr_data;   // transmit data write
  logic txe_r;     // shadow of transmit enable
  logic unread_r;  // buffer holds an unread byte
  logic ove_r;     // expected overrun flag
  logic clean_r;   // flags known to be clear

  assign rd_stat = cpu_req.rd && cpu_req.addr == ADDR_STAT;
  assign rd_baud = cpu_req.rd && cpu_req.addr == ADDR_BAUD;
  assign rd_data = cpu_req.rd && cpu_req.addr == ADDR_DATA;
  assign wr_data = cpu_req.wr && cpu_req.addr == ADDR_DATA;

  // shadow registers follow cpu traffic and frame completions
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txe_r    <= 1'b0;
      unread_r <= 1'b0;
      ove_r    <= 1'b0;
      clean_r  <= 1'b1;
    end
    else
    begin
      if (cpu_req.wr && cpu_req.addr == ADDR_MODE)
        txe_r <= cpu_req.wdata[MODE_TXE];
      unread_r <= rx_done | (unread_r & ~rd_data);
      ove_r    <= rx_done ? (unread_r & ~rd_data) : (ove_r & ~rd_data);
      clean_r  <= ~rx_done & (clean_r | rd_data);
    end
  end

  // ------
  // properties
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_stat_top_zero: assert property (
    rd_stat |=> cpu_rdata[7:3] == 5'h00) else $error("status top bits set");
  a_baud_low_zero: assert property (
    rd_baud |=> cpu_rdata[3:0] == 4'h0) else $error("baud low nibble set");
  a_read_clears: assert property (
    rd_stat && clean_r && !rx_done |=> cpu_rdata == 8'h00)
    else $error("flags not cleared by buffer read");
  a_overrun_flag: assert property (
    rd_stat && !rx_done |=> cpu_rdata[STAT_OVE] == $past(ove_r))
    else $error("overrun flag wrong");
  a_tx_idle_high: assert property (
    !tx_busy |-> txd) else $error("txd low while idle");
  a_tx_start_cause: assert property (
    $rose(tx_busy) |-> !txd && $past(wr_data && txe_r))
    else $error("transmit start without write");
  a_bit_min_len: assert property (
    $fell(txd) |-> (!txd)[*8]) else $error("txd bit too short");
  a_rx_done_pulse: assert property (
    rx_done |=> (!rx_done)[*8]) else $error("rx_done not a pulse");
  a_tx_done_pulse: assert property (
    tx_done |-> ##1 !tx_done ##1 !tx_done) else $error("tx_done not a pulse");

  c_overrun: cover property (rx_done && unread_r);
  c_tx_done: cover property (tx_done);
  c_clean_read: cover property (rd_stat && clean_r);
endmodule  // urps_properties

/* File: sim/urps_peer.sv */
`timescale 1ns/1ns
module urps_peer (
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd
);
  int bit_cyc;  // mclk cycles per bit

  // line idles high, driven from time zero
  initial
  begin
    bit_cyc = 128;
    rxd     = 1'b1;
  end

  // drive n frame bits lsb first, then release the line
  task automatic send(input logic [11:0] f, input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge mclk);
    end
    rxd <= 1'b1;
  endtask

  // sample n bits of a frame at mid bit, start bit first
  task automatic capture(input int n, output logic [11:0] f);
    f = 12'hFFF;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = txd;
      if (i < n - 1)
        repeat (bit_cyc) @(posedge mclk);
    end
  endtask
endmodule  // urps_peer

/* File: sim/tb.sv */
`timescale 1ns/1ns
module tb;
  import urps_pkg::*;

  logic          mclk;
  logic          reset_n;
  urps_cpu_req_t cpu_req;
  logic [7:0]    cpu_rdata;
  logic          rxd;
  logic          txd;
  logic          ext_clk;
  logic          rx_done;
  logic          tx_done;
  logic          tx_busy;
  int            errors;
  int            cmp_count;
  int            rx_cnt;
  int            tx_cnt;

  urps_top urps_top_i (.mclk(mclk), .reset_n(reset_n), .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata), .rxd(rxd), .txd(txd), .external_baud_clock_pin(ext_clk),
    .rx_done(rx_done), .tx_done(tx_done), .tx_busy(tx_busy));
  urps_peer urps_peer_i (.mclk(mclk), .txd(txd), .rxd(rxd));

  // ------
  // clocks and pulse counters
  // ------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    ext_clk = 1'b0;
    forever #40 ext_clk = ~ext_clk;
  end
  always @(posedge mclk)
  begin
    if (rx_done === 1'b1) rx_cnt++;
    if (tx_done === 1'b1) tx_cnt++;
  end

  // ------
  // helpers
  // ------
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk);
    cpu_req.wr <= 1'b0;
  endtask

  // read; data arrives one edge after the strobe is taken
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk);
    cpu_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk);
    cpu_req.rd <= 1'b0;
    @(posedge mclk);
    #1;
    chk($sformatf("reg %h", a), e, cpu_rdata);
  endtask

  task automatic set_mode(input logic [1:0] ps, input logic c8, input logic sl);
    bus_wr(ADDR_MODE, {2'b11, ps, c8, sl, 2'b00});
  endtask

  // expected frame bits, start bit at position 0
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [1:0] ps,
    input logic c8, input logic pf, input logic sb, output int n);
    logic [7:0]  c;
    logic [11:0] f;
    logic        p;
    c = c8 ? d : {1'b0, d[6:0]};
    f = 12'hFFE;
    n = c8 ? 9 : 8;
    for (int i = 0; i < 8; i++)
      if (i < n - 1) f[i + 1] = c[i];
    p = (ps == PAR_ODD) ? ~^c : (ps == PAR_EVEN) ? ^c : 1'b0;
    if (ps != PAR_NONE)
    begin
      f[n] = p ^ pf;
      n++;
    end
    f[n] = sb;
    n++;
    return f;
  endfunction

  task automatic rx_send(input logic [7:0] d, input logic [1:0] ps, input logic c8,
                         input logic pf, input logic sb);
    logic [11:0] f;
    int          n;
    int          c0;
    f = frame(d, ps, c8, pf, sb, n);
    c0 = rx_cnt;
    urps_peer_i.send(f, n);
    chk("rx_done count", 8'(c0 + 1), 8'(rx_cnt));
  endtask

  task automatic wait_tx(input int c0);
    int k;
    k = 0;
    while (tx_busy !== 1'b0 && k < 4000)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    repeat (2) @(posedge mclk);
    chk("tx_done count", 8'(c0 + 1), 8'(tx_cnt));
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_regs;
    rdc(ADDR_STAT, 8'h00);
    rdc(ADDR_BAUD, 8'h00);
    bus_wr(ADDR_STAT, 8'hFF);
    rdc(ADDR_STAT, 8'h00);
    rdc(16'hFF7E, 8'h00);
    bus_wr(ADDR_MODE, 8'h33);
    rdc(ADDR_MODE, 8'h30);
    bus_wr(ADDR_BAUD, 8'h7F);
    rdc(ADDR_BAUD, 8'h70);
    bus_wr(ADDR_BAUD, 8'h20);
  endtask

  task automatic t_rx_par;
    for (int p = 0; p < 4; p++)
      for (int f = 0; f < 2; f++)
      begin
        set_mode(2'(p), 1'b1, 1'b0);
        rx_send(8'hC3 + 8'(p), 2'(p), 1'b1, f[0], 1'b1);
        rdc(ADDR_STAT, {5'h0, f[0] && p >= 2, 2'h0});
        rdc(ADDR_DATA, 8'hC3 + 8'(p));
      end
  endtask

  task automatic t_rx_misc;
    set_mode(PAR_EVEN, 1'b0, 1'b0);
    rx_send(8'hD9, PAR_EVEN, 1'b0, 1'b0, 1'b1);
    rdc(ADDR_STAT, 8'h00);
    rdc(ADDR_DATA, 8'h59);
    set_mode(PAR_NONE, 1'b1, 1'b0);
    rx_send(8'h3C, PAR_NONE, 1'b1, 1'b0, 1'b0);
    rdc(ADDR_STAT, 8'h02);
    rdc(ADDR_DATA, 8'h3C);
  endtask

  // back to back frames with two stop bits set; no read between
  task automatic t_overrun;
    set_mode(PAR_NONE, 1'b1, 1'b1);
    rx_send(8'h11, PAR_NONE, 1'b1, 1'b0, 1'b1);
    rx_send(8'h22, PAR_NONE, 1'b1, 1'b0, 1'b1);
    rdc(ADDR_STAT, 8'h01);
    rx_send(8'h33, PAR_NONE, 1'b1, 1'b0, 1'b1);
    rdc(ADDR_STAT, 8'h01);
    rdc(ADDR_DATA, 8'h33);
    rdc(ADDR_STAT, 8'h00);
    rx_send(8'h44, PAR_NONE, 1'b1, 1'b0, 1'b1);
    rdc(ADDR_STAT, 8'h00);
    rdc(ADDR_DATA, 8'h44);
  endtask

  task automatic t_tx(input logic [7:0] d, input logic [1:0] ps, input logic c8,
                      input logic sl);
    logic [11:0] f;
    logic [11:0] cap;
    int          n;
    int          c0;
    set_mode(ps, c8, sl);
    f = frame(d, ps, c8, 1'b0, 1'b1, n);
    c0 = tx_cnt;
    fork
      bus_wr(ADDR_DATA, d);
      urps_peer_i.capture(n + int'(sl), cap);
    join
    chk("tx frame lo", f[7:0], cap[7:0]);
    chk("tx frame hi", {4'h0, f[11:8]}, {4'h0, cap[11:8]});
    chk("tx busy in stop", 8'h01, {7'h00, tx_busy});
    wait_tx(c0);
  endtask

  // length of data bit 0 in mclk cycles
  task automatic t_baud(input logic [7:0] code, input int exp);
    int c;
    int c0;
    bus_wr(ADDR_BAUD, code);
    c0 = tx_cnt;
    c = 0;
    fork
      bus_wr(ADDR_DATA, 8'h01);
      begin
        @(posedge txd);
        while (txd === 1'b1)
        begin
          @(posedge mclk);
          #1;
          c++;
        end
      end
    join
    cmp_count++;
    if (c != exp)
    begin
      errors++;
      $display("BAD bit length exp %0d got %0d", exp, c);
    end
    wait_tx(c0);
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ------
  // main sequence and watchdog
  // ------
  initial
  begin
    cpu_req = '0;
    reset_n = 1'b0;
    errors = 0;
    cmp_count = 0;
    rx_cnt = 0;
    tx_cnt = 0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs;
    t_rx_par;
    t_rx_misc;
    t_overrun;
    t_tx(8'h13, PAR_EVEN, 1'b1, 1'b0);
    t_tx(8'h13, PAR_ODD, 1'b1, 1'b1);
    t_tx(8'hFF, PAR_ZERO, 1'b1, 1'b0);
    t_tx(8'hF0, PAR_NONE, 1'b0, 1'b0);
    t_tx(8'h81, PAR_EVEN, 1'b0, 1'b1);
    set_mode(PAR_NONE, 1'b1, 1'b0);
    t_baud(8'h20, 128);
    t_baud(8'h30, 256);
    t_baud(8'h80, 128);
    results;
  end
  initial
  begin
    #1000000;
    errors++;
    results;
  end
endmodule  // tb

bind urps_top urps_properties urps_properties_i (.mclk(mclk), .reset_n(reset_n),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .rxd(rxd), .txd(txd),
  .external_baud_clock_pin(external_baud_clock_pin), .rx_done(rx_done),
  .tx_done(tx_done), .tx_busy(tx_busy));
